// file: inc/cc16_defs.vh
// Constants of the sixteen-channel capture/compare unit
// Function
// - Sixteen channels, one-clock resolution, eight clocks when staggered.
// - Two independent 16-bit time bases, each with its own reload register.
// - Each time base counts on a selectable prescaled system clock division.
// - Either time base may count on the neighbour timer's overflow strobe.
// - Time base A may count on an external count input.
// - Sixteen channel registers, each for capture or compare.
// - Each channel picks its time base and capture or compare operation.
// - One pin per channel: capture trigger input or compare event output.
// - Compare mode 0 raises a request per match, pin untouched.
// - Compare mode 1 inverts the pin on every match.
// - Compare mode 2 raises at most one request per timer period.
// - Compare mode 3 sets pin on match, clears on overflow, once per period.
// - Double register pairs share one pin; either match inverts it.
// - Single-event option lets a channel act only once.
// - Capture latches the allocated time base on the selected pin event.
// - Each capture raises that channel's request.
// - Capture edge selectable as rising, falling or both.
// - Compare channels compare against their time base on every count.
// - A match performs the action of the channel's compare mode.
`ifndef CC16_DEFS_VH
`define CC16_DEFS_VH
// Register byte offsets
`define CC16_TCTL_OFS 8'h00
`define CC16_RELA_OFS 8'h04
`define CC16_RELB_OFS 8'h08
`define CC16_TMRA_OFS 8'h0c
`define CC16_TMRB_OFS 8'h10
`define CC16_DBL_OFS 8'h14
`define CC16_DONE_OFS 8'h18
`define CC16_PIN_OFS 8'h1c
`define CC16_VAL_BLK 2'h1
`define CC16_CFG_BLK 2'h2
// Timer control fields
`define CC16_RUNA_BIT 0
`define CC16_SRCA_LSB 1
`define CC16_PREA_LSB 3
`define CC16_RUNB_BIT 8
`define CC16_SRCB_LSB 9
`define CC16_PREB_LSB 11
`define CC16_STAG_BIT 16
// Count sources
`define CC16_SRC_PRE 2'h0
`define CC16_SRC_NB 2'h1
`define CC16_SRC_EXT 2'h2
// Staggered mode floor of the prescaler exponent (eight clocks)
`define CC16_STAG_PRE 3'h3
// Channel configuration fields
`define CC16_MODE_LSB 0
`define CC16_TSEL_BIT 3
`define CC16_SNGL_BIT 4
// Channel modes
`define CC16_M_OFF 3'h0
`define CC16_M_CAPR 3'h1
`define CC16_M_CAPF 3'h2
`define CC16_M_CAPB 3'h3
`define CC16_M_CMP0 3'h4
`define CC16_M_CMP1 3'h5
`define CC16_M_CMP2 3'h6
`define CC16_M_CMP3 3'h7
// Reset values
`define CC16_TCTL_RST 17'h00000
`define CC16_REL_RST 16'h0000
`define CC16_CFG_RST 5'h00
`endif

// file: hw/cc16_timebase.v
// One 16-bit time base with prescaler, source select and reload
`timescale 1ns/1ps
`default_nettype none
`include "cc16_defs.vh"
module cc16_timebase #(
    parameter W = 16,
    parameter PW = 3
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire run_i,
    input wire [1:0] src_i,
    input wire [PW-1:0] pre_i,
    input wire stag_i,
    // Count sources
    input wire nb_ovf_i,
    input wire ext_i,
    // Software load and reload
    input wire ld_i,
    input wire [W-1:0] ld_val_i,
    input wire [W-1:0] rel_i,
    // Time base state
    output reg [W-1:0] cnt_o,
    output reg tick_o,
    output reg ovf_o
);
    localparam DW = 1 << PW;
    reg [DW-1:0] div;
    reg ext_q;
    reg [PW-1:0] eff;
    reg [DW-1:0] mask;
    reg pre_tick;
    reg step;

    always @* begin
        eff = pre_i;
        if (stag_i && pre_i < `CC16_STAG_PRE) begin
            eff = `CC16_STAG_PRE;
        end
        mask = ~({DW{1'b1}} << eff);
        pre_tick = ((div & mask) == mask);
        case (src_i)
            `CC16_SRC_PRE: step = run_i & pre_tick;
            `CC16_SRC_NB: step = run_i & nb_ovf_i;
            `CC16_SRC_EXT: step = run_i & ext_i & ~ext_q;
            default: step = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            div <= {DW{1'b0}};
            ext_q <= 1'b0;
            cnt_o <= {W{1'b0}};
            tick_o <= 1'b0;
            ovf_o <= 1'b0;
        end else begin
            div <= div + 1'b1;
            ext_q <= ext_i;
            tick_o <= step & ~ld_i;
            ovf_o <= 1'b0;
            if (ld_i) begin
                cnt_o <= ld_val_i;
            end else if (step) begin
                if (&cnt_o) begin
                    cnt_o <= rel_i;
                    ovf_o <= 1'b1;
                end else begin
                    cnt_o <= cnt_o + 1'b1;
                end
            end
        end
    end
endmodule // cc16_timebase
`default_nettype wire

// file: hw/cc16_unit.v
// Sixteen-channel capture/compare unit with Wishbone register port
`timescale 1ns/1ps
`default_nettype none
`include "cc16_defs.vh"
module cc16_unit #(
    parameter NCH = 16,
    parameter W = 16
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Count sources
    input wire nb_ovf_i,
    input wire ext_cnt_i,
    // Channel pins
    input wire [NCH-1:0] pin_i,
    output reg [NCH-1:0] pin_o,
    output reg [NCH-1:0] pin_oe_o,
    // Per-channel requests
    output reg [NCH-1:0] irq_o
);
    localparam HALF = NCH / 2;

    // Byte-lane merge of a 16-bit register
    function [15:0] mrg16;
        input [15:0] old;
        input [15:0] dat;
        input [1:0] sel;
        begin
            mrg16 = old;
            if (sel[0]) begin
                mrg16[7:0] = dat[7:0];
            end
            if (sel[1]) begin
                mrg16[15:8] = dat[15:8];
            end
        end
    endfunction

    // Compare modes
    function is_cmp;
        input [2:0] m;
        begin
            is_cmp = m[2];
        end
    endfunction

    reg [16:0] tctl;
    reg [W-1:0] rel_a;
    reg [W-1:0] rel_b;
    reg [HALF-1:0] dbl;
    reg [W-1:0] cval [0:NCH-1];
    reg [4:0] ccfg [0:NCH-1];
    reg [NCH-1:0] done;
    reg [NCH-1:0] fired;
    reg [NCH-1:0] pin_q;

    wire [W-1:0] cnt_a;
    wire [W-1:0] cnt_b;
    wire tick_a;
    wire tick_b;
    wire ovf_a;
    wire ovf_b;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i;
    wire wr = req & wb_we_i & wb_ack_o;
    wire [1:0] blk = wb_adr_i[7:6];
    wire [3:0] idx = wb_adr_i[5:2];
    wire wr_tmra = wr && wb_adr_i == `CC16_TMRA_OFS;
    wire wr_tmrb = wr && wb_adr_i == `CC16_TMRB_OFS;

    cc16_timebase #(
        .W(W),
        .PW(3)
    ) u_base_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(tctl[`CC16_RUNA_BIT]),
        .src_i(tctl[`CC16_SRCA_LSB+:2]),
        .pre_i(tctl[`CC16_PREA_LSB+:3]),
        .stag_i(tctl[`CC16_STAG_BIT]),
        .nb_ovf_i(nb_ovf_i),
        .ext_i(ext_cnt_i),
        .ld_i(wr_tmra),
        .ld_val_i(mrg16(cnt_a, wb_dat_i[15:0], wb_sel_i[1:0])),
        .rel_i(rel_a),
        .cnt_o(cnt_a),
        .tick_o(tick_a),
        .ovf_o(ovf_a)
    );

    // Time base B has no external input; that source leaves it still
    cc16_timebase #(
        .W(W),
        .PW(3)
    ) u_base_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(tctl[`CC16_RUNB_BIT]),
        .src_i(tctl[`CC16_SRCB_LSB+:2]),
        .pre_i(tctl[`CC16_PREB_LSB+:3]),
        .stag_i(tctl[`CC16_STAG_BIT]),
        .nb_ovf_i(nb_ovf_i),
        .ext_i(1'b0),
        .ld_i(wr_tmrb),
        .ld_val_i(mrg16(cnt_b, wb_dat_i[15:0], wb_sel_i[1:0])),
        .rel_i(rel_b),
        .cnt_o(cnt_b),
        .tick_o(tick_b),
        .ovf_o(ovf_b)
    );

    // Per-channel events
    reg [NCH-1:0] cap_ev;
    reg [NCH-1:0] match;
    reg [NCH-1:0] t_ovf;
    reg [NCH-1:0] tog;
    reg [NCH-1:0] set3;
    reg [NCH-1:0] drive;
    reg [2:0] md;
    reg [W-1:0] tv;
    reg tk;
    reg rise;
    reg fall;
    integer i;
    integer tgt;

    always @* begin
        cap_ev = {NCH{1'b0}};
        match = {NCH{1'b0}};
        t_ovf = {NCH{1'b0}};
        tog = {NCH{1'b0}};
        set3 = {NCH{1'b0}};
        drive = {NCH{1'b0}};
        md = 3'h0;
        tv = {W{1'b0}};
        tk = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        tgt = 0;
        for (i = 0; i < NCH; i = i + 1) begin
            md = ccfg[i][`CC16_MODE_LSB+:3];
            tv = ccfg[i][`CC16_TSEL_BIT] ? cnt_b : cnt_a;
            tk = ccfg[i][`CC16_TSEL_BIT] ? tick_b : tick_a;
            t_ovf[i] = ccfg[i][`CC16_TSEL_BIT] ? ovf_b : ovf_a;
            rise = pin_i[i] & ~pin_q[i];
            fall = ~pin_i[i] & pin_q[i];
            case (md)
                `CC16_M_CAPR: cap_ev[i] = rise & ~done[i];
                `CC16_M_CAPF: cap_ev[i] = fall & ~done[i];
                `CC16_M_CAPB: cap_ev[i] = (rise | fall) & ~done[i];
                default: cap_ev[i] = 1'b0;
            endcase
            // Compare on every count of the allocated time base
            if (is_cmp(md) && tk && tv == cval[i] && !done[i]) begin
                match[i] = 1'b1;
                if ((md == `CC16_M_CMP2 || md == `CC16_M_CMP3) && fired[i]) begin
                    match[i] = 1'b0;
                end
            end
            // Pair partner drives the lower pin of a double pair
            tgt = i;
            if (i >= HALF && dbl[i-HALF]) begin
                tgt = i - HALF;
            end
            if (match[i]) begin
                if (i >= HALF ? dbl[i-HALF] : dbl[i]) begin
                    tog[tgt] = 1'b1;
                end else if (md == `CC16_M_CMP1) begin
                    tog[i] = 1'b1;
                end else if (md == `CC16_M_CMP3) begin
                    set3[i] = 1'b1;
                end
            end
            if (i < HALF && dbl[i]) begin
                drive[i] = 1'b1;
            end else if (!(i >= HALF && dbl[i-HALF])) begin
                drive[i] = (md == `CC16_M_CMP1) || (md == `CC16_M_CMP3);
            end
        end
    end

    // Channel, pin and request state
    integer k;
    always @(posedge clk_i) begin
        if (rst_i) begin
            done <= {NCH{1'b0}};
            fired <= {NCH{1'b0}};
            pin_q <= {NCH{1'b0}};
            pin_o <= {NCH{1'b0}};
            pin_oe_o <= {NCH{1'b0}};
            irq_o <= {NCH{1'b0}};
            for (k = 0; k < NCH; k = k + 1) begin
                cval[k] <= {W{1'b0}};
                ccfg[k] <= `CC16_CFG_RST;
            end
        end else begin
            pin_q <= pin_i;
            pin_oe_o <= drive;
            irq_o <= cap_ev | match;
            for (k = 0; k < NCH; k = k + 1) begin
                // Software access; hardware events below take precedence
                if (wr && blk == `CC16_VAL_BLK && idx == k) begin
                    cval[k] <= mrg16(cval[k], wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                if (wr && blk == `CC16_CFG_BLK && idx == k && wb_sel_i[0]) begin
                    ccfg[k] <= wb_dat_i[4:0];
                    done[k] <= 1'b0;
                    fired[k] <= 1'b0;
                end
                if (cap_ev[k]) begin
                    cval[k] <= (ccfg[k][`CC16_TSEL_BIT] ? cnt_b : cnt_a);
                end
                // Once-per-period state restarts at overflow
                if (t_ovf[k]) begin
                    fired[k] <= 1'b0;
                end
                if (match[k]) begin
                    fired[k] <= 1'b1;
                end
                if ((match[k] | cap_ev[k]) && ccfg[k][`CC16_SNGL_BIT]) begin
                    done[k] <= 1'b1;
                end
                // Pin action; a match wins over the overflow clear
                if (tog[k]) begin
                    pin_o[k] <= ~pin_o[k];
                end else if (set3[k]) begin
                    pin_o[k] <= 1'b1;
                end else if (t_ovf[k] && ccfg[k][2:0] == `CC16_M_CMP3 &&
                             !(k < HALF && dbl[k]) &&
                             !(k >= HALF && dbl[k-HALF])) begin
                    pin_o[k] <= 1'b0;
                end
            end
        end
    end

    // Global registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            tctl <= `CC16_TCTL_RST;
            rel_a <= `CC16_REL_RST;
            rel_b <= `CC16_REL_RST;
            dbl <= {HALF{1'b0}};
        end else if (wr) begin
            case (wb_adr_i)
                `CC16_TCTL_OFS: begin
                    if (wb_sel_i[0]) begin
                        tctl[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        tctl[15:8] <= wb_dat_i[15:8];
                    end
                    if (wb_sel_i[2]) begin
                        tctl[16] <= wb_dat_i[16];
                    end
                end
                `CC16_RELA_OFS: rel_a <= mrg16(rel_a, wb_dat_i[15:0], wb_sel_i[1:0]);
                `CC16_RELB_OFS: rel_b <= mrg16(rel_b, wb_dat_i[15:0], wb_sel_i[1:0]);
                `CC16_DBL_OFS: begin
                    if (wb_sel_i[0]) begin
                        dbl <= wb_dat_i[HALF-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux
    reg [31:0] rd;
    always @* begin
        rd = 32'h0;
        case (blk)
            `CC16_VAL_BLK: rd[W-1:0] = cval[idx];
            `CC16_CFG_BLK: rd[4:0] = ccfg[idx];
            default: begin
                case (wb_adr_i)
                    `CC16_TCTL_OFS: rd[16:0] = tctl;
                    `CC16_RELA_OFS: rd[W-1:0] = rel_a;
                    `CC16_RELB_OFS: rd[W-1:0] = rel_b;
                    `CC16_TMRA_OFS: rd[W-1:0] = cnt_a;
                    `CC16_TMRB_OFS: rd[W-1:0] = cnt_b;
                    `CC16_DBL_OFS: rd[HALF-1:0] = dbl;
                    `CC16_DONE_OFS: rd[NCH-1:0] = done;
                    `CC16_PIN_OFS: rd[NCH-1:0] = pin_o;
                    default: rd = 32'h0;
                endcase
            end
        endcase
    end

    // Wishbone answer: one wait state, ack for one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= wb_we_i ? 32'h0 : rd;
            end
        end
    end
endmodule // cc16_unit
`default_nettype wire

// file: bench/cc16_unit_chk.sv
// Port assertions for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module cc16_unit_chk #(
    parameter NCH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and requests
    input wire logic [NCH-1:0] pin_o,
    input wire logic [NCH-1:0] pin_oe_o,
    input wire logic [NCH-1:0] irq_o
);
    default clocking @(posedge clk_i); endclocking
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    a_ack_one_wait: assert property (disable iff (rst_i) req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_reset_quiet: assert property (rst_i |=> !wb_ack_o && pin_o == '0
        && pin_oe_o == '0 && irq_o == '0) else $error("outputs not cleared by reset");
    a_unmapped_zero: assert property (disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pin_readback: assert property (disable iff (rst_i)
        req && !wb_we_i && wb_adr_i[7:2] == 6'h07 |=> wb_dat_o[NCH-1:0] == $past(pin_o))
        else $error("pin readback differs from pins");
    a_oe_after_cfg: assert property (disable iff (rst_i)
        $changed(pin_oe_o) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2)
        || $past(wb_ack_o && wb_we_i, 3) || $past(rst_i)) else $error("enable moved alone");
    a_rise_irq: assert property (disable iff (rst_i)
        !$past(rst_i) && (pin_o & ~$past(pin_o)) != '0 |-> irq_o != '0)
        else $error("pin rose without request");
endmodule // cc16_unit_chk
bind cc16_unit cc16_unit_chk #(.NCH(NCH)) i_cc16_unit_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .irq_o(irq_o));
`default_nettype wire

// file: bench/cc16_pins.sv
// External pin model: driven pins read back, others follow the bench level
`timescale 1ns/1ps
`default_nettype none
module cc16_pins (
    // From the unit
    input wire logic [15:0] drv_i,
    input wire logic [15:0] oe_i,
    // Outside level
    input wire logic [15:0] lvl_i,
    // To the unit
    output logic [15:0] pin_o
);
    assign pin_o = (oe_i & drv_i) | (~oe_i & lvl_i);
endmodule // cc16_pins
`default_nettype wire

// file: bench/cc16_unit_tb.sv
// Self-checking testbench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module cc16_unit_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic nb_ovf_i = 1'b0;
    logic ext_cnt_i = 1'b0;
    logic [15:0] lvl = 16'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [15:0] pin_i, pin_o, pin_oe_o, irq_o;
    int err_count = 0;
    int checked = 0;
    int irq_cnt[16];
    int seed = 47;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    logic [15:0] v;
    cc16_unit i_cc16_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nb_ovf_i(nb_ovf_i),
        .ext_cnt_i(ext_cnt_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .irq_o(irq_o));
    cc16_pins i_cc16_pins (.drv_i(pin_o), .oe_i(pin_oe_o), .lvl_i(lvl), .pin_o(pin_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Result watcher: counts requests, compares read data at ack
    always @(posedge clk_i) begin
        for (int i = 0; i < 16; i++) begin
            if (irq_o[i] === 1'b1) irq_cnt[i]++;
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            e = exp_q.pop_front();
            `CHK(wb_dat_o, e)
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] d);
        exp_q.push_back({16'h0, d});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic cfg(input int c, input logic [15:0] m, input logic [15:0] val);
        wr(8'(8'h40 + 4 * c), val);
        wr(8'(8'h80 + 4 * c), m);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            nb_ovf_i <= 1'b1;
            @(posedge clk_i);
            nb_ovf_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 16'h0);
        rd(8'h0c, 16'h0);
        wr(8'h20, 16'hffff);
        rd(8'h20, 16'h0);
        $display("test reset done");
        // Both bases on neighbour strobes, A wraps through its reload
        wr(8'h00, 16'h0303);
        wr(8'h04, 16'h1234);
        wr(8'h0c, 16'hfffe);
        wr(8'h10, 16'h0000);
        pulse(3);
        rd(8'h04, 16'h1234);
        rd(8'h0c, 16'h1235);
        rd(8'h10, 16'h0003);
        $display("test reload done");
        wr(8'h00, 16'h0305);
        wr(8'h0c, 16'h0000);
        repeat (5) begin
            @(posedge clk_i);
            ext_cnt_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            ext_cnt_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        rd(8'h0c, 16'h0005);
        rd(8'h10, 16'h0003);
        $display("test external done");
        // Capture on static bases: rise, fall, both, and base B
        wr(8'h00, 16'h0303);
        v = 16'($random(seed));
        wr(8'h0c, v);
        wr(8'h10, 16'h0bbb);
        cfg(2, 16'h1, 16'h0);
        cfg(3, 16'h2, 16'h0);
        cfg(4, 16'h3, 16'h0);
        cfg(5, 16'h9, 16'h0);
        @(posedge clk_i);
        lvl <= 16'h003c;
        repeat (4) @(posedge clk_i);
        wr(8'h0c, v + 16'h1);
        @(posedge clk_i);
        lvl <= 16'h0000;
        repeat (4) @(posedge clk_i);
        rd(8'h48, v);
        rd(8'h4c, v + 16'h1);
        rd(8'h50, v + 16'h1);
        rd(8'h54, 16'h0bbb);
        `CHK(irq_cnt[2], 1)
        `CHK(irq_cnt[3], 1)
        `CHK(irq_cnt[4], 2)
        `CHK(irq_cnt[5], 1)
        $display("test capture done");
        // Compare modes, pair 0 and single event, three passes over 3
        wr(8'h04, 16'h0000);
        wr(8'h14, 16'h0001);
        cfg(0, 16'h5, 16'h3);
        cfg(8, 16'h5, 16'h2);
        cfg(11, 16'h4, 16'h3);
        cfg(12, 16'h5, 16'h3);
        cfg(13, 16'h6, 16'h3);
        cfg(14, 16'h7, 16'h3);
        cfg(15, 16'h15, 16'h3);
        wr(8'h0c, 16'h0001);
        pulse(1);
        rd(8'h1c, 16'h0001);
        pulse(1);
        rd(8'h1c, 16'hd000);
        wr(8'h0c, 16'h0001);
        pulse(2);
        rd(8'h1c, 16'hc000);
        rd(8'h18, 16'h8000);
        wr(8'h0c, 16'hffff);
        pulse(1);
        rd(8'h1c, 16'h8000);
        pulse(3);
        rd(8'h1c, 16'hd000);
        `CHK(pin_o, 16'hd000)
        `CHK(pin_oe_o, 16'hd001)
        `CHK(irq_cnt[11], 3)
        `CHK(irq_cnt[12], 3)
        `CHK(irq_cnt[13], 2)
        `CHK(irq_cnt[14], 2)
        `CHK(irq_cnt[15], 1)
        `CHK(irq_cnt[1], 0)
        $display("test compare done");
        // Prescaled counts over 64 clocks: divide 2, then staggered divide 8
        wr(8'h0c, 16'h0000);
        wr(8'h00, 16'h0009);
        repeat (61) @(posedge clk_i);
        wr(8'h00, 16'h0000);
        rd(8'h0c, 16'h0020);
        wr(8'h0c, 16'h0000);
        bus(1'b1, 8'h00, 32'h00010001);
        repeat (61) @(posedge clk_i);
        wr(8'h00, 16'h0000);
        rd(8'h0c, 16'h0008);
        $display("test prescale done");
        repeat (2) @(posedge clk_i);
        finish_test;
    end
endmodule // cc16_unit_tb
`default_nettype wire
